// ===== pulse_mod_regs.svh
/*
 Register offsets, field positions and reset values of the four-channel
 pulse modulator. Assumes inclusion by bare name from design files.
*/
`ifndef PULSE_MOD_REGS_SVH
`define PULSE_MOD_REGS_SVH

`define OFS_SHARED_CLOCK_SETUP 12'h000
`define OFS_CHANNEL_ENABLE_SET 12'h004
`define OFS_CHANNEL_ENABLE_CLEAR 12'h008
`define OFS_CHANNEL_RUNNING_STATE 12'h00c
`define OFS_IRQ_MASK_SET 12'h010
`define OFS_IRQ_MASK_CLEAR 12'h014
`define OFS_IRQ_MASK_STATE 12'h018
`define OFS_PERIOD_END_FLAGS 12'h01c
`define OFS_CH_BASE 12'h200
`define OFS_CH_STRIDE_LSB 5
`define OFS_CH_WAVEFORM 5'h00
`define OFS_CH_DUTY 5'h04
`define OFS_CH_PERIOD 5'h08
`define OFS_CH_COUNTER 5'h0c
`define OFS_CH_UPDATE 5'h10

`define FLD_DIV_A_LSB 0
`define FLD_PRE_A_LSB 8
`define FLD_DIV_B_LSB 16
`define FLD_PRE_B_LSB 24
`define FLD_CLK_SEL_LSB 0
`define FLD_ALIGN_BIT 8
`define FLD_POLARITY_BIT 9
`define FLD_UPDATE_TARGET_BIT 10

`define SEL_SHARED_A 4'hb
`define SEL_SHARED_B 4'hc
`define PRESCALE_MAX 4'ha

`define RST_SHARED_CLOCK_SETUP 32'h0000_0000
`define RST_WAVEFORM 11'h000
`define RST_VALUE 16'h0000

`endif

// ===== pulse_mod_pkg.sv
/*
 Types of the four-channel pulse modulator.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package pulse_mod_pkg;
   typedef enum logic [0:0] {
      CNT_UP = 1'b0,
      CNT_DOWN = 1'b1
   } count_dir_e;
endpackage

// ===== four_channel_pulse_modulator.sv
/*
 Four-channel pulse modulator with an APB slave, two shared divided
 clocks, period-end interrupts and double-buffered duty or period.
 Assumes a single 125 MHz clock, synchronous active-low reset and an APB
 master that holds a transfer until pready.
*/
// Decided for this implementation: the APB slave port and the register addresses.
// Function
// - Divide factor zero stops shared clock
// - Factor one passes chosen prescaler tap
// - Factors 2..255 further divide prescaler tap
// - Enable register ones start channels
// - Disable register ones stop channels
// - Running state shows enabled channels
// - Mask set ones enable channel interrupts
// - Mask clear ones disable channel interrupts
// - Mask state shows enabled interrupts
// - Flag set after any completed period
// - Reading flags clears only the flags it returned
// - Alignment bit selects left or center
// - Polarity bit sets period start level
// - Update target one retargets period
// - Update target zero retargets duty
// - Counter up then down or wraps
// - Interrupt holds until flags read or its mask cleared
`timescale 1ns/100ps
`include "pulse_mod_regs.svh"

module four_channel_pulse_modulator #(
   parameter int CHANNELS = 4,
   parameter int CNT_W = 16
)(
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [CHANNELS-1:0] wave_out,
   output logic irq
);
   logic [31:0] shared_clock_setup_r;
   logic [CHANNELS-1:0] running_r;
   logic [CHANNELS-1:0] irq_mask_r;
   logic [CHANNELS-1:0] period_end_flags_r;
   logic [10:0] waveform_r [CHANNELS];
   logic [CNT_W-1:0] duty_r [CHANNELS];
   logic [CNT_W-1:0] period_r [CHANNELS];
   logic [CNT_W-1:0] count_r [CHANNELS];
   logic [CNT_W-1:0] update_r [CHANNELS];
   logic [CHANNELS-1:0] update_pend_r;
   pulse_mod_pkg::count_dir_e dir_r [CHANNELS];
   logic [CHANNELS-1:0] level_r;
   logic [9:0] pre_cnt_r;
   logic [7:0] div_a_cnt_r;
   logic [7:0] div_b_cnt_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   logic irq_r;

   // Tick of the prescaler tap 2^code: all low bits of the counter set
   function automatic logic tap_tick(input logic [9:0] cnt,
      input logic [3:0] code);
      logic [9:0] mask;
      mask = 10'h000;
      tap_tick = 1'b0;
      if (code <= `PRESCALE_MAX)
      begin
         mask = 10'((11'h001 << code) - 11'h001);
         tap_tick = ((cnt & mask) == mask);
      end
   endfunction

   wire [7:0] div_a = shared_clock_setup_r[`FLD_DIV_A_LSB +: 8];
   wire [3:0] pre_a = shared_clock_setup_r[`FLD_PRE_A_LSB +: 4];
   wire [7:0] div_b = shared_clock_setup_r[`FLD_DIV_B_LSB +: 8];
   wire [3:0] pre_b = shared_clock_setup_r[`FLD_PRE_B_LSB +: 4];
   wire tap_a = tap_tick(pre_cnt_r, pre_a);
   wire tap_b = tap_tick(pre_cnt_r, pre_b);
   wire div_a_wrap = (div_a_cnt_r >= div_a - 8'h01);
   wire div_b_wrap = (div_b_cnt_r >= div_b - 8'h01);
   // Zero factor gates the shared clock off; one passes the tap
   wire shared_clock_a = (div_a != 8'h00) && tap_a && div_a_wrap;
   wire shared_clock_b = (div_b != 8'h00) && tap_b && div_b_wrap;

   // APB decode: one wait-free access phase
   wire acc = psel && penable;
   wire wr = acc && pwrite;
   wire rd = acc && !pwrite;
   wire in_ch = (paddr[11:9] == 3'b001);
   wire [1:0] ch_idx = paddr[6:5];
   wire [4:0] ch_ofs = paddr[4:0];
   wire ch_hit = in_ch && (paddr[8:7] == 2'b00) &&
      (32'(ch_idx) < CHANNELS) && (paddr[1:0] == 2'b00);
   wire hit_glob = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'b00);
   wire hit = hit_glob || (ch_hit && (ch_ofs <= `OFS_CH_UPDATE));
   wire wr_setup = wr && (paddr == `OFS_SHARED_CLOCK_SETUP);
   wire wr_ena = wr && (paddr == `OFS_CHANNEL_ENABLE_SET);
   wire wr_dis = wr && (paddr == `OFS_CHANNEL_ENABLE_CLEAR);
   wire wr_ier = wr && (paddr == `OFS_IRQ_MASK_SET);
   wire wr_idr = wr && (paddr == `OFS_IRQ_MASK_CLEAR);
   wire rd_flags = rd && (paddr == `OFS_PERIOD_END_FLAGS);
   wire [CHANNELS-1:0] wbits = pwdata[CHANNELS-1:0];

   logic [CHANNELS-1:0] ch_tick;
   logic [CHANNELS-1:0] period_end;
   logic [31:0] ch_rdata [CHANNELS];

   genvar g;
   generate
      for (g = 0; g < CHANNELS; g++)
      begin : chan
         wire sel_me = ch_hit && (32'(ch_idx) == g);
         wire wr_mode = wr && sel_me && (ch_ofs == `OFS_CH_WAVEFORM);
         wire wr_duty = wr && sel_me && (ch_ofs == `OFS_CH_DUTY);
         wire wr_prd = wr && sel_me && (ch_ofs == `OFS_CH_PERIOD);
         wire wr_upd = wr && sel_me && (ch_ofs == `OFS_CH_UPDATE);
         wire [3:0] csel = waveform_r[g][`FLD_CLK_SEL_LSB +: 4];
         wire center = waveform_r[g][`FLD_ALIGN_BIT];
         wire pol = waveform_r[g][`FLD_POLARITY_BIT];
         wire upd_prd = waveform_r[g][`FLD_UPDATE_TARGET_BIT];
         wire start_ch = wr_ena && wbits[g];
         // Clock select: taps 0..10, shared A at 11, shared B at 12
         assign ch_tick[g] = (csel == `SEL_SHARED_A) ? shared_clock_a :
            (csel == `SEL_SHARED_B) ? shared_clock_b :
            tap_tick(pre_cnt_r, csel);
         wire at_top = (count_r[g] >= period_r[g]);
         wire at_zero = (count_r[g] == '0);
         // Left wraps so that one period lasts exactly period_value ticks
         wire [CNT_W-1:0] last = (period_r[g] == '0) ? '0 :
            period_r[g] - CNT_W'(1);
         // Center turns at the top without repeating the top count
         wire down_step = center &&
            (dir_r[g] == pulse_mod_pkg::CNT_DOWN || at_top);
         wire ends = running_r[g] && ch_tick[g] &&
            (center ? (down_step && count_r[g] == CNT_W'(1)) ||
            (period_r[g] == '0) : count_r[g] >= last);
         assign period_end[g] = ends;
         wire [CNT_W-1:0] cnt_nxt = !running_r[g] ? count_r[g] :
            !ch_tick[g] ? count_r[g] :
            ends ? '0 :
            down_step ? count_r[g] - CNT_W'(1) :
            count_r[g] + CNT_W'(1);
         wire dir_flip = center && ch_tick[g] && running_r[g] &&
            ((dir_r[g] == pulse_mod_pkg::CNT_UP && at_top) ||
            (dir_r[g] == pulse_mod_pkg::CNT_DOWN && at_zero));
         // Output starts each period at the polarity level; toggles at duty
         wire active = (count_r[g] < duty_r[g]);
         wire lvl_nxt = running_r[g] ? (active ? pol : !pol) : 1'b0;
         assign ch_rdata[g] = (ch_ofs == `OFS_CH_WAVEFORM) ?
            {21'h0, waveform_r[g]} :
            (ch_ofs == `OFS_CH_DUTY) ? 32'(duty_r[g]) :
            (ch_ofs == `OFS_CH_PERIOD) ? 32'(period_r[g]) :
            (ch_ofs == `OFS_CH_COUNTER) ? 32'(count_r[g]) : 32'h0;

         always_ff @(posedge clk)
         begin
            if (!nrst)
            begin
               waveform_r[g] <= `RST_WAVEFORM;
               duty_r[g] <= `RST_VALUE;
               period_r[g] <= `RST_VALUE;
               count_r[g] <= `RST_VALUE;
               update_r[g] <= `RST_VALUE;
               update_pend_r[g] <= 1'b0;
               dir_r[g] <= pulse_mod_pkg::CNT_UP;
               level_r[g] <= 1'b0;
            end
            else
            begin
               // Mode changes while running are ignored to avoid glitches
               if (wr_mode && !running_r[g])
                  waveform_r[g] <= pwdata[10:0];
               if (wr_upd)
                  update_r[g] <= pwdata[CNT_W-1:0];
               if (wr_upd)
                  update_pend_r[g] <= 1'b1;
               else if (ends)
                  update_pend_r[g] <= 1'b0;
               if (ends && update_pend_r[g] && upd_prd)
                  period_r[g] <= update_r[g];
               else if (wr_prd && !running_r[g])
                  period_r[g] <= pwdata[CNT_W-1:0];
               if (ends && update_pend_r[g] && !upd_prd)
                  duty_r[g] <= update_r[g];
               else if (wr_duty && !running_r[g])
                  duty_r[g] <= pwdata[CNT_W-1:0];
               if (start_ch && !running_r[g])
                  count_r[g] <= '0;
               else
                  count_r[g] <= cnt_nxt;
               if ((start_ch && !running_r[g]) || ends)
                  dir_r[g] <= pulse_mod_pkg::CNT_UP;
               else if (dir_flip)
                  dir_r[g] <= (dir_r[g] == pulse_mod_pkg::CNT_UP) ?
                     pulse_mod_pkg::CNT_DOWN : pulse_mod_pkg::CNT_UP;
               level_r[g] <= lvl_nxt;
            end
         end
      end
   endgenerate

   wire [31:0] glob_rdata =
      (paddr == `OFS_SHARED_CLOCK_SETUP) ? shared_clock_setup_r :
      (paddr == `OFS_CHANNEL_RUNNING_STATE) ? 32'(running_r) :
      (paddr == `OFS_IRQ_MASK_STATE) ? 32'(irq_mask_r) :
      (paddr == `OFS_PERIOD_END_FLAGS) ? 32'(period_end_flags_r) : 32'h0;
   wire [31:0] rdata_nxt = !hit ? 32'h0 :
      hit_glob ? glob_rdata : ch_rdata[ch_idx];

   // Only bits already returned are cleared and a new set still wins,
   // so a period end landing during the read is never lost
   wire [CHANNELS-1:0] flags_nxt = (period_end_flags_r &
      ~(rd_flags ? prdata_r[CHANNELS-1:0] : '0)) | period_end;
   wire [CHANNELS-1:0] mask_nxt =
      (irq_mask_r | (wr_ier ? wbits : '0)) & ~(wr_idr ? wbits : '0);
   wire [CHANNELS-1:0] run_nxt =
      (running_r | (wr_ena ? wbits : '0)) & ~(wr_dis ? wbits : '0);

   always_ff @(posedge clk)
   begin
      if (!nrst)
      begin
         shared_clock_setup_r <= `RST_SHARED_CLOCK_SETUP;
         running_r <= '0;
         irq_mask_r <= '0;
         period_end_flags_r <= '0;
         pre_cnt_r <= 10'h000;
         div_a_cnt_r <= 8'h00;
         div_b_cnt_r <= 8'h00;
         prdata_r <= 32'h0;
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         irq_r <= 1'b0;
      end
      else
      begin
         if (wr_setup)
            shared_clock_setup_r <= pwdata & 32'h0fff_0fff;
         running_r <= run_nxt;
         irq_mask_r <= mask_nxt;
         period_end_flags_r <= flags_nxt;
         pre_cnt_r <= pre_cnt_r + 10'h001;
         if (div_a == 8'h00)
            div_a_cnt_r <= 8'h00;
         else if (tap_a)
            div_a_cnt_r <= div_a_wrap ? 8'h00 : div_a_cnt_r + 8'h01;
         if (div_b == 8'h00)
            div_b_cnt_r <= 8'h00;
         else if (tap_b)
            div_b_cnt_r <= div_b_wrap ? 8'h00 : div_b_cnt_r + 8'h01;
         prdata_r <= (psel && !penable && !pwrite) ? rdata_nxt : 32'h0;
         pready_r <= psel && !penable;
         pslverr_r <= psel && !penable && !hit;
         irq_r <= |(flags_nxt & mask_nxt);
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign wave_out = level_r;
   assign irq = irq_r;
endmodule

// ===== pulse_mod_properties.sv
/*
 Port checker for the four-channel pulse modulator.
 Assumes one clock, sync active-low reset, bound to the top module.
*/
`timescale 1ns/100ps
module pulse_mod_properties #(
   parameter int CHANNELS = 4
)(
   input wire logic clk,
   input wire logic nrst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [CHANNELS-1:0] wave_out,
   input wire logic irq
);
   wire acc = psel && penable && pready;
   wire wr = acc && pwrite;
   wire rd = acc && !pwrite;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   a_ready_first: assert property (psel && !penable |=> pready)
      else $error("pready missing in access phase");
   a_ready_single: assert property (pready |=> !pready)
      else $error("pready held past access");
   a_err_unmapped: assert property (acc && paddr == 12'h040 |-> pslverr)
      else $error("unmapped access without pslverr");
   a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside access");
   a_state_width: assert property (
      rd && paddr == 12'h00c |-> prdata[31:4] == 28'h0)
      else $error("running state has upper bits");
   a_irq_hold: assert property (
      irq && !acc && !$past(acc) |=> irq)
      else $error("irq dropped without bus access");
   a_dis_stops: assert property (wr && paddr == 12'h008 |->
      ##2 (wave_out & $past(pwdata[CHANNELS-1:0], 2)) == '0)
      else $error("disabled channel still drives");
   a_mask_clr_irq: assert property (
      wr && paddr == 12'h014 && pwdata[3:0] == 4'hf |-> ##2 !irq)
      else $error("irq high with all masks cleared");
   c_irq: cover property ($rose(irq));
   c_err: cover property (acc && pslverr);
   c_flags: cover property (rd && paddr == 12'h01c && prdata[0]);
endmodule
bind four_channel_pulse_modulator pulse_mod_properties #(
   .CHANNELS(CHANNELS)) i_props (.clk(clk), .nrst(nrst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .wave_out(wave_out), .irq(irq));

// ===== four_channel_pulse_modulator_test.sv
/*
 Self-checking bench for the four-channel pulse modulator.
 Assumes the design answers APB within 50 clocks of the access phase.
*/
`timescale 1ns/100ps
module four_channel_pulse_modulator_test;
   logic clk, nrst, psel, penable, pwrite, pready, pslverr, irq, e;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic [3:0] wave_out;
   int err_count = 0;
   int n_tests = 0;
   four_channel_pulse_modulator i_dut (.clk(clk), .nrst(nrst),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .wave_out(wave_out), .irq(irq));
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task summarize;
      if (err_count == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         err_count++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task hang;
      err_count++;
      $display("CHECK FAILED %0t wait timed out", $time);
      summarize;
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      // Values read right after the edge are the ones that edge sampled
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1)
         hang;
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   task wl(input logic v, output int n);
      n = 0;
      do
      begin
         @(posedge clk);
         #1;
         n++;
      end
      while (wave_out[0] !== v && n < 3000);
      if (wave_out[0] !== v)
         hang;
   endtask
   task meas(input logic [31:0] cmr, prd, dty, upd, input int ep, eh);
      int h, l;
      wr(12'h008, 32'h1);
      wr(12'h200, cmr);
      wr(12'h204, dty);
      wr(12'h208, prd);
      wr(12'h004, 32'h1);
      if (upd != 0)
         wr(12'h210, upd);
      // Two whole periods let the update land and the start settle
      repeat (2)
      begin
         wl(1'b0, h);
         wl(1'b1, h);
      end
      wl(1'b0, h);
      wl(1'b1, l);
      chk(h + l, ep);
      if (eh >= 0)
         chk(h, eh);
   endtask
   task t_reset;
      rd(12'h000, 32'h0);
      rd(12'h00c, 32'h0);
      rd(12'h018, 32'h0);
      rd(12'h01c, 32'h0);
      rd(12'h200, 32'h0);
      chk({irq, wave_out}, 5'h00);
   endtask
   task t_enable;
      wr(12'h004, 32'h5);
      rd(12'h00c, 32'h5);
      wr(12'h004, 32'h2);
      rd(12'h00c, 32'h7);
      wr(12'h008, 32'h4);
      rd(12'h00c, 32'h3);
      wr(12'h008, 32'h0);
      rd(12'h00c, 32'h3);
      wr(12'h008, 32'hf);
      rd(12'h00c, 32'h0);
      rd(12'h040, 32'h0);
      chk(e, 1'b1);
      rd(12'h01c, 32'h7);
   endtask
   task t_mask;
      wr(12'h010, 32'h9);
      rd(12'h018, 32'h9);
      wr(12'h010, 32'h2);
      rd(12'h018, 32'hb);
      wr(12'h014, 32'h1);
      rd(12'h018, 32'ha);
      wr(12'h014, 32'hf);
      rd(12'h018, 32'h0);
   endtask
   task t_waves;
      wr(12'h000, 32'h0201_0103);
      rd(12'h000, 32'h0201_0103);
      meas(32'h000, 4, 1, 0, 4, 3);
      meas(32'h200, 4, 1, 0, 4, 1);
      meas(32'h100, 4, 1, 0, 8, -1);
      meas(32'h002, 4, 1, 0, 16, 12);
      meas(32'h00b, 4, 1, 0, 24, 18);
      meas(32'h00c, 4, 1, 0, 16, 12);
      meas(32'h400, 4, 1, 8, 8, 7);
      meas(32'h000, 4, 1, 3, 4, 1);
   endtask
   task t_stop;
      wr(12'h000, 32'h0201_0100);
      wr(12'h008, 32'h1);
      wr(12'h200, 32'h00b);
      wr(12'h004, 32'h1);
      repeat (100) @(posedge clk);
      rd(12'h20c, 32'h0);
      wr(12'h000, 32'h0201_0103);
   endtask
   task t_irq;
      int n;
      meas(32'h000, 4, 1, 0, 4, 3);
      wr(12'h200, 32'h200);
      rd(12'h200, 32'h0);
      wr(12'h010, 32'h1);
      n = 0;
      while (irq !== 1'b1 && n++ < 200)
         @(posedge clk);
      chk(irq, 1'b1);
      rd(12'h01c, 32'h1);
      wr(12'h008, 32'h1);
      apb(1'b0, 12'h01c, 32'h0);
      rd(12'h01c, 32'h0);
      repeat (2) @(posedge clk);
      chk(irq, 1'b0);
   endtask
   initial
   begin
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      t_reset;
      t_enable;
      t_mask;
      t_waves;
      t_stop;
      t_irq;
      summarize;
   end
endmodule
